// >>> pkg/sac_pkg.sv
package sac_pkg;
    // ----------------------------------------------------------------
    // sizes
    // ----------------------------------------------------------------
    localparam int NCH = 8;
    localparam int FW = 8;
    localparam int NGRP = 10;
    localparam int MUTE_W = 16;
    localparam int NBTN = 9;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_TIME_US = 1000;
    localparam int TICK_CYC = TICK_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int HOLD_TIME_MS = 250;
    localparam int HOLD_TICKS = HOLD_TIME_MS * 1000 / TICK_TIME_US;
    // one extra tick covers the partial first tick, so a long press is never early
    localparam logic [7:0] HOLD_LAST = 8'(HOLD_TICKS);

    // ----------------------------------------------------------------
    // values and reset values
    // ----------------------------------------------------------------
    localparam logic [6:0] NUM_MIN = 7'h00;
    localparam logic [6:0] NUM_MAX = 7'h63;
    localparam logic [FW-1:0] FADER_REF = 8'hc0;

    // button positions in the edge vector
    localparam int B_LOCK = 0;
    localparam int B_CGM = 1;
    localparam int B_MUM = 2;
    localparam int B_ACTSC = 3;
    localparam int B_UP = 4;
    localparam int B_DOWN = 5;
    localparam int B_STORE = 6;
    localparam int B_CONF = 7;
    localparam int B_SYS = 8;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_MENU = 3'b010,
        ST_OVER = 3'b100
    } sac_state_t;

    typedef enum logic [1:0] {
        FM_REAL = 2'h0,
        FM_VSTORE = 2'h1,
        FM_VRECALL = 2'h2
    } sac_fmode_t;

    typedef enum logic [1:0] {
        LK_NONE = 2'h0,
        LK_SYS = 2'h1,
        LK_TOTAL = 2'h2
    } sac_lock_t;
endpackage

// >>> pkg/sac_key_if.sv
`timescale 1ns/1ns
// one panel key between the control block and its press timer
interface sac_key_if (
    input wire logic core_clk,
    input wire logic rst_b
);
    logic key;
    logic tick;
    logic short_p;
    logic long_p;

    modport timer (input core_clk, input rst_b, input key, input tick,
                   output short_p, output long_p);
    modport user (output key, output tick, input short_p, input long_p);
endinterface

// >>> logic/sac_keytimer.sv
`timescale 1ns/1ns
module sac_keytimer
    import sac_pkg::*;
(
    // key and its press classes
    sac_key_if.timer k
);
    logic key_prev_reg;
    logic long_seen_reg;
    logic [7:0] hold_cnt_reg;

    // count held ticks, class press at release or at the hold threshold
    always_ff @(posedge k.core_clk or negedge k.rst_b) begin
        if (!k.rst_b) begin
            key_prev_reg <= 1'b0;
            long_seen_reg <= 1'b0;
            hold_cnt_reg <= 8'h00;
            k.short_p <= 1'b0;
            k.long_p <= 1'b0;
        end else begin
            key_prev_reg <= k.key;
            k.short_p <= 1'b0;
            k.long_p <= 1'b0;
            if (!k.key) begin
                hold_cnt_reg <= 8'h00;
                long_seen_reg <= 1'b0;
                k.short_p <= key_prev_reg && !long_seen_reg;
            end else if (!long_seen_reg && k.tick) begin
                if (hold_cnt_reg == HOLD_LAST) begin
                    long_seen_reg <= 1'b1;
                    k.long_p <= 1'b1;
                end else begin
                    hold_cnt_reg <= hold_cnt_reg + 8'h01;
                end
            end
        end
    end

    long_held_a: assert property (@(posedge k.core_clk) disable iff (!k.rst_b)
        k.long_p |-> $past(k.key, 1) && $past(k.tick, 1))
        else $error("long press flagged without a held key");
endmodule

// >>> logic/sac_scene_ctrl.sv
`timescale 1ns/1ns
// Function
// - fader safe on: virtual fader follows real fader, no group or automation effect.
// - isolation ends only after safe switch off and a later scene recall.
// - a store writes exactly what the indicators show, isolated faders included.
// - real fader mode: stored fader positions equal real fader positions.
// - virtual store mode: recall restores stored level until real fader moves.
// - virtual recall mode: level is stored value plus real fader offset.
// - overstore is refused while virtual recall mode is active.
// - virtual recall mode lit: no fader positions are captured into a scene.
// - panel lock ignores assign keys, mode switches and channel set switches.
// - group or mute mode key lights itself and sets that assignment mode.
// - short assign press selects only that key; long press adds it.
// - short set press toggles channel groups by selection; long press replaces them.
// - scene saves faders plus all mute states.
// - act/scene key picks the edited field and lights its indicator.
// - up/down step the field through 00 to 99, wrapping both ways.
// - store to unused number writes at once and shows done.
// - store to used number prompts, waits for confirm, then writes and shows done.
// - lock level is scrolled in the system menu and taken on confirm.
module sac_scene_ctrl
    import sac_pkg::*;
#(
    parameter int TICK_CYC_P = TICK_CYC
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // panel keys, high while pressed
    input wire logic lock_key,
    input wire logic cg_mode_key,
    input wire logic mute_mode_key,
    input wire logic act_scene_key,
    input wire logic up_key,
    input wire logic down_key,
    input wire logic store_key,
    input wire logic confirm_key,
    input wire logic system_key,
    input wire logic [NGRP-1:0] assign_key,
    input wire logic [NCH-1:0] set_key,
    // channel strip state
    input wire logic [NCH-1:0] fader_safe,
    input wire logic [NCH-1:0] auto_safe,
    input wire logic [NCH-1:0][FW-1:0] real_fader,
    input wire logic [1:0] fader_mode,
    input wire logic [MUTE_W-1:0] auto_mute,
    // scene memory
    input wire logic mem_used,
    input wire logic recall_valid,
    input wire logic [NCH-1:0][FW-1:0] recall_fader,
    output logic mem_wr,
    output logic [6:0] mem_act,
    output logic [6:0] mem_scene,
    output logic [NCH-1:0][FW-1:0] mem_fader,
    output logic [MUTE_W-1:0] mem_mute,
    output logic [NCH-1:0][NGRP-1:0] mem_cg,
    output logic [NCH-1:0][NGRP-1:0] mem_mg,
    // indicators and display
    output logic [NCH-1:0][FW-1:0] virt_fader,
    output logic lock_lamp,
    output logic cg_mode_lamp,
    output logic mute_mode_lamp,
    output logic [NGRP-1:0] assign_lamp,
    output logic [NCH-1:0][NGRP-1:0] cg_assign,
    output logic [NCH-1:0][NGRP-1:0] mg_assign,
    output logic act_lamp,
    output logic scene_lamp,
    output logic [6:0] act_num,
    output logic [6:0] scene_num,
    output logic msg_done,
    output logic msg_over,
    output logic store_refused,
    output logic menu_active,
    output logic [1:0] lock_level,
    output logic total_lock_level
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    sac_state_t state_reg;
    logic [15:0] tick_cnt_reg;
    logic tick_reg;
    logic [NBTN-1:0] btn;
    logic [NBTN-1:0] btn_prev_reg;
    logic [NBTN-1:0] press;
    logic [NGRP-1:0] as_short;
    logic [NGRP-1:0] as_long;
    logic [NCH-1:0] set_short;
    logic [NCH-1:0] set_long;
    logic [NCH-1:0] iso_reg;
    logic [NCH-1:0] pick_reg;
    logic [NCH-1:0][FW-1:0] stored_reg;
    logic [NCH-1:0][FW-1:0] snap_reg;
    logic [NCH-1:0][FW-1:0] virt_next;
    logic [NGRP-1:0] assign_next;
    logic [1:0] cursor_reg;
    logic panel_lock;
    logic vrecall;
    logic wr_go;

    function automatic logic [6:0] step_num(input logic [6:0] n, input logic up);
        if (up) begin
            return (n == NUM_MAX) ? NUM_MIN : n + 7'h01;
        end
        return (n == NUM_MIN) ? NUM_MAX : n - 7'h01;
    endfunction

    assign vrecall = (fader_mode == FM_VRECALL);
    assign panel_lock = lock_lamp || (lock_level == LK_TOTAL);

    // ----------------------------------------------------------------
    // key timing
    // ----------------------------------------------------------------
    // millisecond enable for the press timers
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_cnt_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (tick_cnt_reg == 16'(TICK_CYC_P - 1));
            if (tick_cnt_reg == 16'(TICK_CYC_P - 1)) begin
                tick_cnt_reg <= 16'h0000;
            end else begin
                tick_cnt_reg <= tick_cnt_reg + 16'h0001;
            end
        end
    end

    // one press timer per assign key and per channel set key
    generate
        for (genvar i = 0; i < NGRP; i++) begin : g_as
            sac_key_if kif (.core_clk(core_clk), .rst_b(rst_b));
            assign kif.key = assign_key[i];
            assign kif.tick = tick_reg;
            assign as_short[i] = kif.short_p;
            assign as_long[i] = kif.long_p;
            sac_keytimer u_kt (.k(kif));
        end
        for (genvar c = 0; c < NCH; c++) begin : g_set
            sac_key_if kif (.core_clk(core_clk), .rst_b(rst_b));
            assign kif.key = set_key[c];
            assign kif.tick = tick_reg;
            assign set_short[c] = kif.short_p;
            assign set_long[c] = kif.long_p;
            sac_keytimer u_kt (.k(kif));
        end
    endgenerate

    // press edges of the single keys
    assign btn = {system_key, confirm_key, store_key, down_key, up_key,
                  act_scene_key, mute_mode_key, cg_mode_key, lock_key};
    assign press = btn & ~btn_prev_reg;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            btn_prev_reg <= '0;
        end else begin
            btn_prev_reg <= btn;
        end
    end

    // ----------------------------------------------------------------
    // fader handling
    // ----------------------------------------------------------------
    // isolation, recalled level and pick-up tracking per channel
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            iso_reg <= '0;
            pick_reg <= '0;
            stored_reg <= '0;
            snap_reg <= '0;
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (fader_safe[c]) begin
                    iso_reg[c] <= 1'b1;
                end else if (recall_valid) begin
                    iso_reg[c] <= 1'b0;
                end
                if (recall_valid && !auto_safe[c] && !iso_reg[c] && !fader_safe[c]) begin
                    stored_reg[c] <= recall_fader[c];
                    snap_reg[c] <= real_fader[c];
                    pick_reg[c] <= 1'b0;
                end else if (real_fader[c] != snap_reg[c]) begin
                    pick_reg[c] <= 1'b1;
                end
            end
        end
    end

    // level shown per channel for the active fader mode
    always_comb begin
        logic signed [9:0] sum;
        sum = '0;
        virt_next = real_fader;
        for (int c = 0; c < NCH; c++) begin
            if (fader_safe[c] || iso_reg[c]) begin
                virt_next[c] = real_fader[c];
            end else if (fader_mode == FM_VSTORE) begin
                virt_next[c] = pick_reg[c] ? real_fader[c] : stored_reg[c];
            end else if (vrecall) begin
                sum = $signed({2'b00, stored_reg[c]}) + $signed({2'b00, real_fader[c]})
                      - $signed({2'b00, FADER_REF});
                if (sum < 0) begin
                    virt_next[c] = '0;
                end else if (sum > 10'sh0ff) begin
                    virt_next[c] = 8'hff;
                end else begin
                    virt_next[c] = sum[FW-1:0];
                end
            end else begin
                virt_next[c] = real_fader[c];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            virt_fader <= '0;
        end else begin
            virt_fader <= virt_next;
        end
    end

    // ----------------------------------------------------------------
    // assignment keys
    // ----------------------------------------------------------------
    // mode lamps and panel lock lamp
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            lock_lamp <= 1'b0;
            cg_mode_lamp <= 1'b0;
            mute_mode_lamp <= 1'b0;
        end else begin
            if (press[B_LOCK]) begin
                lock_lamp <= !lock_lamp;
            end
            if (!panel_lock && press[B_CGM]) begin
                cg_mode_lamp <= 1'b1;
                mute_mode_lamp <= 1'b0;
            end else if (!panel_lock && press[B_MUM]) begin
                cg_mode_lamp <= 1'b0;
                mute_mode_lamp <= 1'b1;
            end
        end
    end

    // assign key selection: short is exclusive, long adds
    always_comb begin
        assign_next = assign_lamp;
        if (!panel_lock) begin
            for (int i = 0; i < NGRP; i++) begin
                if (as_short[i]) begin
                    assign_next = '0;
                    assign_next[i] = 1'b1;
                end
            end
            for (int i = 0; i < NGRP; i++) begin
                if (as_long[i]) begin
                    assign_next[i] = 1'b1;
                end
            end
        end
    end

    // channel assignment by set keys in the lit mode
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            assign_lamp <= '0;
            cg_assign <= '0;
            mg_assign <= '0;
        end else begin
            assign_lamp <= assign_next;
            for (int c = 0; c < NCH; c++) begin
                if (!panel_lock && cg_mode_lamp) begin
                    if (set_long[c]) begin
                        cg_assign[c] <= assign_lamp;
                    end else if (set_short[c]) begin
                        cg_assign[c] <= cg_assign[c] ^ assign_lamp;
                    end
                end
                if (!panel_lock && mute_mode_lamp) begin
                    if (set_long[c]) begin
                        mg_assign[c] <= assign_lamp;
                    end else if (set_short[c]) begin
                        mg_assign[c] <= mg_assign[c] ^ assign_lamp;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // act/scene number
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            act_lamp <= 1'b1;
            scene_lamp <= 1'b0;
            act_num <= NUM_MIN;
            scene_num <= NUM_MIN;
        end else if (state_reg == ST_IDLE) begin
            if (press[B_ACTSC]) begin
                act_lamp <= !act_lamp;
                scene_lamp <= act_lamp;
            end
            if (press[B_UP] != press[B_DOWN]) begin
                if (act_lamp) begin
                    act_num <= step_num(act_num, press[B_UP]);
                end else begin
                    scene_num <= step_num(scene_num, press[B_UP]);
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // store sequence and lock menu
    // ----------------------------------------------------------------
    assign wr_go = !vrecall && !(state_reg == ST_IDLE && press[B_SYS])
                   && ((state_reg == ST_IDLE && press[B_STORE] && !mem_used)
                   || (state_reg == ST_OVER && press[B_CONF]));

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            cursor_reg <= LK_NONE;
            lock_level <= LK_NONE;
            total_lock_level <= 1'b0;
            menu_active <= 1'b0;
            msg_done <= 1'b0;
            msg_over <= 1'b0;
            store_refused <= 1'b0;
        end else begin
            if (wr_go) begin
                msg_done <= 1'b1;
                msg_over <= 1'b0;
            end
            unique case (state_reg)
                ST_IDLE: begin
                    if (press[B_SYS]) begin
                        state_reg <= ST_MENU;
                        menu_active <= 1'b1;
                        cursor_reg <= lock_level;
                    end else if (press[B_STORE]) begin
                        msg_done <= !vrecall && !mem_used;
                        store_refused <= vrecall;
                        if (!vrecall && mem_used) begin
                            state_reg <= ST_OVER;
                            msg_over <= 1'b1;
                        end
                    end
                end
                ST_MENU: begin
                    if (press[B_UP] && !press[B_DOWN]) begin
                        cursor_reg <= (cursor_reg == LK_TOTAL) ? LK_NONE : cursor_reg + 2'h1;
                    end else if (press[B_DOWN] && !press[B_UP]) begin
                        cursor_reg <= (cursor_reg == LK_NONE) ? LK_TOTAL : cursor_reg - 2'h1;
                    end
                    if (press[B_CONF]) begin
                        lock_level <= cursor_reg;
                        total_lock_level <= (cursor_reg == LK_TOTAL);
                    end
                    if (press[B_CONF] || press[B_SYS]) begin
                        state_reg <= ST_IDLE;
                        menu_active <= 1'b0;
                    end
                end
                ST_OVER: begin
                    if (press[B_CONF] || press[B_STORE] || vrecall) begin
                        state_reg <= ST_IDLE;
                        msg_over <= 1'b0;
                        store_refused <= vrecall;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // scene image handed to memory
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mem_wr <= 1'b0;
            mem_act <= NUM_MIN;
            mem_scene <= NUM_MIN;
            mem_fader <= '0;
            mem_mute <= '0;
            mem_cg <= '0;
            mem_mg <= '0;
        end else begin
            mem_wr <= wr_go;
            if (wr_go) begin
                mem_act <= act_num;
                mem_scene <= scene_num;
                mem_fader <= virt_fader;
                mem_mute <= auto_mute;
                mem_cg <= cg_assign;
                mem_mg <= mg_assign;
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    iso_snap_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        fader_safe[0] |=> virt_fader[0] == $past(real_fader[0]))
        else $error("isolated fader not following real fader");
    iso_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        iso_reg[0] && !recall_valid |=> iso_reg[0])
        else $error("isolation ended without a recall");
    store_img_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        mem_wr |-> mem_fader == $past(virt_fader) && mem_mute == $past(auto_mute))
        else $error("stored image differs from shown state");
    real_mode_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        fader_mode == FM_REAL ##2 mem_wr |-> mem_fader == $past(real_fader, 2))
        else $error("real mode store not equal to real faders");
    ovr_refuse_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        vrecall |=> !mem_wr)
        else $error("store accepted in virtual recall mode");
    lock_ign_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        panel_lock |=> $stable(cg_assign) && $stable(assign_lamp))
        else $error("panel keys acted while locked");
    mode_lamp_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        !panel_lock && press[B_CGM] |=> cg_mode_lamp && !mute_mode_lamp)
        else $error("group mode key did not light");
    num_wrap_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_reg == ST_IDLE && act_lamp && press[B_DOWN] && !press[B_UP]
        && act_num == NUM_MIN |=> act_num == NUM_MAX)
        else $error("act number did not wrap down");
    new_store_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_reg == ST_IDLE && press[B_STORE] && !press[B_SYS] && !mem_used && !vrecall
        |=> mem_wr && msg_done)
        else $error("new scene not stored at once");
    over_wait_a: assert property (@(posedge core_clk) disable iff (!rst_b)
        state_reg == ST_OVER && !press[B_CONF] |=> !mem_wr)
        else $error("overwrite without confirm");

    over_done_c: cover property (@(posedge core_clk) disable iff (!rst_b)
        state_reg == ST_OVER ##[1:20] mem_wr);
    long_set_c: cover property (@(posedge core_clk) disable iff (!rst_b)
        set_long[0] && cg_mode_lamp);
    total_lock_c: cover property (@(posedge core_clk) disable iff (!rst_b)
        $rose(total_lock_level));
endmodule

// >>> dv/sac_panel_model.sv
`timescale 1ns/1ns
// front panel keys: single keys, then assign keys, then set keys
module sac_panel_model
    import sac_pkg::*;
(
    // clock
    input wire logic core_clk,
    // keys, high while pressed
    output logic [NBTN+NGRP+NCH-1:0] keys
);
    initial keys = '0;
    // hold one key for some cycles, release, let the effect land
    task automatic press(input int i, input int hold);
        @(negedge core_clk) keys[i] = 1'b1;
        repeat (hold) @(negedge core_clk);
        keys[i] = 1'b0;
        repeat (5) @(negedge core_clk);
    endtask
endmodule

// >>> dv/sac_scene_ctrl_tb.sv
`timescale 1ns/1ns
module sac_scene_ctrl_tb
    import sac_pkg::*;
;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int A = NBTN;
    localparam int S = NBTN + NGRP;
    localparam int L = 1100;
    logic core_clk = 0, rst_b = 0, mem_used = 0, recall_valid = 0;
    logic mem_wr, lock_lamp, cg_mode_lamp, mute_mode_lamp, act_lamp, scene_lamp;
    logic msg_done, msg_over, store_refused, menu_active, total_lock_level;
    logic [6:0] mem_act, mem_scene, act_num, scene_num;
    logic [1:0] fader_mode = 0, lock_level;
    logic [NGRP-1:0] assign_lamp;
    logic [NCH-1:0] fader_safe = 0, auto_safe = 0;
    logic [MUTE_W-1:0] auto_mute = 16'ha5a5, mem_mute;
    logic [NCH-1:0][FW-1:0] real_fader = 64'h1020_3040_5060_7080, recall_fader = 0;
    logic [NCH-1:0][FW-1:0] mem_fader, virt_fader;
    logic [NCH-1:0][NGRP-1:0] mem_cg, mem_mg, cg_assign, mg_assign;
    logic [NBTN+NGRP+NCH-1:0] k;
    int n_errors = 0, comparisons = 0, n_wr = 0;

    sac_panel_model u_pan (.core_clk(core_clk), .keys(k));
    sac_scene_ctrl #(.TICK_CYC_P(4)) u_dut (.lock_key(k[B_LOCK]), .cg_mode_key(k[B_CGM]),
        .mute_mode_key(k[B_MUM]), .act_scene_key(k[B_ACTSC]), .up_key(k[B_UP]),
        .down_key(k[B_DOWN]), .store_key(k[B_STORE]), .confirm_key(k[B_CONF]),
        .system_key(k[B_SYS]), .assign_key(k[A+:NGRP]), .set_key(k[S+:NCH]), .*);

    // ------------------------------------------------------------
    // clock, write counter, checks
    // ------------------------------------------------------------
    always #10 core_clk = ~core_clk;
    always @(negedge core_clk) if (mem_wr === 1'b1) n_wr++;

    // one-cycle recall pulse, then let the level settle
    task automatic recall;
        @(negedge core_clk) recall_valid = 1;
        @(negedge core_clk) recall_valid = 0;
        repeat (3) @(negedge core_clk);
    endtask

    task automatic chk(input logic [191:0] got, input logic [191:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test;
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // watchdog: tests take about 2400 cycles
    initial begin
        #400000;
        n_errors++;
        finish_test();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(negedge core_clk);
        rst_b = 1;
        chk(act_lamp, 1);
        u_pan.press(B_ACTSC, 1);
        chk({act_lamp, scene_lamp}, 2'h1);
        u_pan.press(B_DOWN, 1);
        chk(scene_num, 7'h63);
        u_pan.press(B_UP, 1);
        chk(scene_num, 7'h00);
        u_pan.press(B_CGM, 1);
        chk({cg_mode_lamp, mute_mode_lamp}, 2'h2);
        u_pan.press(A + 3, 1);
        chk(assign_lamp, 10'h008);
        u_pan.press(A + 5, L);
        chk(assign_lamp, 10'h028);
        u_pan.press(S + 2, 1);
        chk(cg_assign, 80'h28 << 20);
        u_pan.press(A + 0, 1);
        u_pan.press(S + 2, 1);
        chk(cg_assign, 80'h29 << 20);
        u_pan.press(S + 2, L);
        chk(cg_assign, 80'h1 << 20);
        u_pan.press(B_LOCK, 1);
        u_pan.press(B_MUM, 1);
        u_pan.press(A + 7, 1);
        chk({lock_lamp, mute_mode_lamp, assign_lamp}, 12'h801);
        u_pan.press(B_LOCK, 1);
        u_pan.press(B_MUM, 1);
        u_pan.press(S + 3, 1);
        chk({mute_mode_lamp, mg_assign}, {1'b1, 80'h1 << 30});
        u_pan.press(B_UP, 1);
        u_pan.press(B_STORE, 1);
        chk({n_wr[3:0], msg_done, mem_mute, mem_fader}, {5'h3, auto_mute, real_fader});
        chk({mem_act, mem_scene, mem_cg, mem_mg}, {14'h0001, 80'h1 << 20, 80'h1 << 30});
        mem_used = 1;
        u_pan.press(B_STORE, 1);
        chk({n_wr[3:0], msg_over, msg_done}, 6'h06);
        u_pan.press(B_CONF, 1);
        chk({n_wr[3:0], msg_over, msg_done}, 6'h09);
        fader_mode = 2;
        u_pan.press(B_STORE, 1);
        chk({n_wr[3:0], store_refused}, 5'h05);
        fader_mode = 1;
        recall_fader = {NCH{8'h90}};
        recall();
        chk(virt_fader[1:0], 16'h9090);
        fader_safe = 8'h01;
        repeat (3) @(negedge core_clk);
        chk(virt_fader[0], 8'h80);
        fader_safe = 8'h00;
        repeat (3) @(negedge core_clk);
        chk(virt_fader[0], 8'h80);
        recall();
        chk(virt_fader[0], 8'h90);
        real_fader[1] = 8'h71;
        repeat (3) @(negedge core_clk);
        chk(virt_fader[1], 8'h71);
        fader_mode = 2;
        repeat (3) @(negedge core_clk);
        chk(virt_fader[1:0], 16'h4150);
        u_pan.press(B_SYS, 1);
        chk(menu_active, 1);
        u_pan.press(B_UP, 1);
        u_pan.press(B_UP, 1);
        u_pan.press(B_CONF, 1);
        chk({menu_active, lock_level, total_lock_level}, 4'h5);
        u_pan.press(B_CGM, 1);
        chk(cg_mode_lamp, 0);
        finish_test();
    end
endmodule
